/* verilog/cell_pkg.sv */
/*
 * Constants and types shared by the logic cell: register offsets, field
 * positions, reset values and the enumerations of modes and schemes.
 * Assumes an AXI4-Lite master with 32-bit data and byte addressing.
 */
package cell_pkg;
    // Register byte offsets
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] LUT_MASK_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    // Reset values
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [15:0] LUT_MASK_RESET = 16'h0000;
    // Configuration field positions
    localparam int MODE_LSB = 0;
    localparam int SCHEME_LSB = 2;
    localparam int PRESET_INV_BIT = 5;
    localparam int CE_FROM_A_BIT = 6;
    localparam int CARRY_SEL_BIT = 7;
    localparam int CASCADE_EN_BIT = 8;
    localparam int CASCADE_OR_BIT = 9;
    localparam int PACKED_BIT = 10;
    localparam int FF_TYPE_LSB = 11;
    localparam int LOCAL_REG_BIT = 14;
    localparam int GLOBAL_REG_BIT = 15;
    localparam int CHIP_RESET_EN_BIT = 16;
    // Status field positions
    localparam int STAT_Q_BIT = 0;
    localparam int STAT_LOCAL_BIT = 1;
    localparam int STAT_GLOBAL_BIT = 2;
    localparam int STAT_CARRY_BIT = 3;
    localparam int STAT_CASCADE_BIT = 4;
    localparam int STAT_TRI_BIT = 5;
    localparam int STAT_OVERRIDE_BIT = 6;
    // Number of emulated tri-state sources
    localparam int TRI_SOURCES = 4;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_ARITH, MODE_UPDOWN, MODE_CLEARABLE} mode_t;
    typedef enum logic [2:0] {SCH_CLEAR, SCH_PRESET, SCH_CLEAR_PRESET, SCH_LOAD_CLEAR,
                              SCH_LOAD_PRESET, SCH_LOAD_ONLY} scheme_t;
    typedef enum logic [2:0] {FF_D, FF_T, FF_JK, FF_SR, FF_BYPASS} ff_t;
endpackage

/* verilog/logic_cell.sv */
/*
 * One programmable logic cell: table, flip-flop, carry and cascade chain,
 * asynchronous clear/preset/load schemes, chip reset and tri-state
 * emulation, configured over an AXI4-Lite slave.
 * Assumes all inputs are synchronous to clk_i and the neighbouring cells
 * drive carry and cascade inputs from the same clock.
 */
`timescale 1ns/1ps
module logic_cell (
    input wire logic clk_i,
    input wire logic resetn_i,
    // AXI4-Lite slave
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [7:0] awaddr_i,
    input wire logic wvalid_i,
    output logic wready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    output logic bvalid_o,
    input wire logic bready_i,
    output logic [1:0] bresp_o,
    input wire logic arvalid_i,
    output logic arready_o,
    input wire logic [7:0] araddr_i,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    // Cell data inputs
    input wire logic cell_input_a_i,
    input wire logic cell_input_b_i,
    input wire logic cell_input_c_i,
    input wire logic cell_input_d_i,
    input wire logic carry_in_i,
    input wire logic cascade_in_i,
    // Group controls, asserted high after the group's programmable inversion; chip reset is active low
    input wire logic group_control_first_i,
    input wire logic group_control_second_i,
    input wire logic chip_reset_n_i,
    // Tri-state emulation sources
    input wire logic [3:0] tri_data_i,
    input wire logic [3:0] tri_enable_i,
    // Cell outputs
    output logic local_out_o,
    output logic global_out_o,
    output logic carry_out_o,
    output logic cascade_out_o,
    output logic tri_bus_o
);
    // Whole module state, registered in one place
    typedef struct packed {
        logic [31:0] config_word; // Mode and routing configuration
        logic [15:0] lut_mask;    // Table contents
        logic phys_q;             // Physical flip-flop, possibly inverted
        logic aw_held;            // Write address taken
        logic [7:0] aw_addr;
        logic w_held;             // Write data taken
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t state;      // Current state
    state_t next_state; // Value for the next edge

    // Decoded configuration
    cell_pkg::mode_t mode;
    cell_pkg::scheme_t scheme;
    cell_pkg::ff_t ff_type;
    logic preset_inv, ce_from_a, carry_sel, cascade_en, cascade_or, packed_reg;
    logic local_reg, global_reg, chip_reset_en;
    // Datapath nets
    logic [3:0] lut_idx;
    logic [2:0] half_idx;
    logic lut_out, half_sum, half_carry, comb_result, reg_data, next_q;
    logic cascade_use, ce_eff, inverted, clr_n, pre_n, override_act, phys_view, cell_q;
    logic [31:0] status_word;

    // Register index: 0 config, 1 table, 2 status, 3 unmapped
    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        if (addr == cell_pkg::CONFIG_OFFSET) begin
            return 2'h0;
        end
        if (addr == cell_pkg::LUT_MASK_OFFSET) begin
            return 2'h1;
        end
        if (addr == cell_pkg::STATUS_OFFSET) begin
            return 2'h2;
        end
        return 2'h3;
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Cascade link: AND, or OR built from inverted AND
    function automatic logic cascade_join(input logic value, input logic chain, input logic use_or);
        if (use_or) begin
            return ~(~value & ~chain);
        end
        return value & chain;
    endfunction

    // Config field extraction
    assign mode = cell_pkg::mode_t'(state.config_word[cell_pkg::MODE_LSB +: 2]);
    assign scheme = cell_pkg::scheme_t'(state.config_word[cell_pkg::SCHEME_LSB +: 3]);
    assign ff_type = cell_pkg::ff_t'(state.config_word[cell_pkg::FF_TYPE_LSB +: 3]);
    assign preset_inv = state.config_word[cell_pkg::PRESET_INV_BIT];
    assign ce_from_a = state.config_word[cell_pkg::CE_FROM_A_BIT];
    assign carry_sel = state.config_word[cell_pkg::CARRY_SEL_BIT];
    assign cascade_en = state.config_word[cell_pkg::CASCADE_EN_BIT];
    assign cascade_or = state.config_word[cell_pkg::CASCADE_OR_BIT];
    assign packed_reg = state.config_word[cell_pkg::PACKED_BIT];
    assign local_reg = state.config_word[cell_pkg::LOCAL_REG_BIT];
    assign global_reg = state.config_word[cell_pkg::GLOBAL_REG_BIT];
    assign chip_reset_en = state.config_word[cell_pkg::CHIP_RESET_EN_BIT];

    // Asynchronous clear/preset decode into active-low register controls
    always_comb begin
        inverted = 1'b0;
        clr_n = 1'b1;
        pre_n = 1'b1;
        unique case (scheme)
            cell_pkg::SCH_CLEAR: begin
                clr_n = ~(group_control_first_i | group_control_second_i);
            end
            cell_pkg::SCH_PRESET: begin
                if (preset_inv) begin
                    // Clear with register in and out inverted reads as preset
                    inverted = 1'b1;
                    clr_n = ~group_control_first_i;
                end else begin
                    pre_n = ~group_control_first_i;
                end
            end
            cell_pkg::SCH_CLEAR_PRESET: begin
                pre_n = ~group_control_first_i;
                clr_n = ~group_control_second_i;
            end
            cell_pkg::SCH_LOAD_CLEAR: begin
                pre_n = ~(group_control_first_i & cell_input_c_i);
                clr_n = ~((group_control_first_i & ~cell_input_c_i) | group_control_second_i);
            end
            cell_pkg::SCH_LOAD_PRESET: begin
                // Stored inverted, so the loaded data is inverted to match
                inverted = 1'b1;
                pre_n = ~(group_control_first_i & ~cell_input_c_i);
                clr_n = ~((group_control_first_i & cell_input_c_i) | group_control_second_i);
            end
            cell_pkg::SCH_LOAD_ONLY: begin
                pre_n = ~(group_control_first_i & cell_input_c_i);
                clr_n = ~(group_control_first_i & ~cell_input_c_i);
            end
            default: begin
                // Unused scheme code: controls stay released
                inverted = 1'b0;
            end
        endcase
        // Chip reset clears the physical flop over every scheme
        if (chip_reset_en && !chip_reset_n_i) begin
            clr_n = 1'b0;
            pre_n = 1'b1;
        end
    end

    // The override shows at once; the flop captures it at the next edge
    assign override_act = ~clr_n | ~pre_n;
    assign phys_view = !clr_n ? 1'b0 : (!pre_n ? 1'b1 : state.phys_q);
    assign cell_q = inverted ? ~phys_view : phys_view;
    assign ce_eff = ce_from_a ? cell_input_a_i : 1'b1;
    assign cascade_use = cascade_en & ~packed_reg;

    // Half-table index per mode; counters feed back the register and count enable
    always_comb begin
        unique case (mode)
            cell_pkg::MODE_NORMAL, cell_pkg::MODE_ARITH: begin
                half_idx = {carry_in_i, cell_input_b_i, cell_input_a_i};
            end
            cell_pkg::MODE_UPDOWN: half_idx = {cascade_in_i, cell_q, carry_in_i & cell_input_b_i};
            cell_pkg::MODE_CLEARABLE: half_idx = {1'b0, cell_q, carry_in_i & cell_input_b_i};
        endcase
    end

    // Lower half of the mask is the result table, upper half the carry; kept apart
    // so the mode routing never reads a table bit left over from the last pass
    assign half_sum = state.lut_mask[{1'b0, half_idx}];
    assign half_carry = state.lut_mask[{1'b1, half_idx}];

    // Table and mode routing
    always_comb begin
        lut_idx = {cell_input_d_i, carry_sel ? carry_in_i : cell_input_c_i, cell_input_b_i, cell_input_a_i};
        lut_out = state.lut_mask[lut_idx];
        comb_result = lut_out;
        reg_data = lut_out;
        carry_out_o = carry_in_i;
        cascade_out_o = lut_out;
        unique case (mode)
            cell_pkg::MODE_NORMAL: begin
                cascade_out_o = cascade_use ? cascade_join(lut_out, cascade_in_i, cascade_or) : lut_out;
                comb_result = cascade_out_o;
                // Packed: d goes straight to the flop, table is free
                reg_data = packed_reg ? cell_input_d_i : comb_result;
            end
            cell_pkg::MODE_ARITH: begin
                cascade_out_o = cascade_en ? cascade_join(half_sum, cascade_in_i, cascade_or) : half_sum;
                comb_result = cascade_out_o;
                reg_data = comb_result;
                carry_out_o = half_carry;
            end
            cell_pkg::MODE_UPDOWN: begin
                // b enables counting, cascade-in gives direction, d loads c
                comb_result = half_sum;
                reg_data = cell_input_d_i ? cell_input_c_i : half_sum;
                carry_out_o = half_carry;
                cascade_out_o = 1'b1;
            end
            cell_pkg::MODE_CLEARABLE: begin
                // Cascade-in is the active-low synchronous clear
                comb_result = half_sum;
                reg_data = (cell_input_d_i ? cell_input_c_i : half_sum) & cascade_in_i;
                carry_out_o = half_carry;
                cascade_out_o = 1'b1;
            end
        endcase
    end

    // Flip-flop personality
    always_comb begin
        unique case (ff_type)
            cell_pkg::FF_D: next_q = reg_data;
            cell_pkg::FF_T: next_q = cell_q ^ reg_data;
            cell_pkg::FF_JK: next_q = (reg_data & ~cell_q) | (~cell_input_b_i & cell_q);
            cell_pkg::FF_SR: next_q = reg_data ? 1'b1 : (cell_input_b_i ? 1'b0 : cell_q);
            cell_pkg::FF_BYPASS: next_q = reg_data;
            default: next_q = cell_q;
        endcase
    end

    // Output selection; bypass sends the table result to both outputs
    assign local_out_o = (local_reg && ff_type != cell_pkg::FF_BYPASS) ? cell_q : comb_result;
    assign global_out_o = (global_reg && ff_type != cell_pkg::FF_BYPASS) ? cell_q : comb_result;

    // Tri-state emulation by multiplexer: contention low, float high
    always_comb begin
        tri_bus_o = 1'b1;
        if ($countones(tri_enable_i) > 1) begin
            tri_bus_o = 1'b0;
        end else begin
            for (int i = 0; i < cell_pkg::TRI_SOURCES; i++) begin
                if (tri_enable_i[i]) begin
                    tri_bus_o = tri_data_i[i];
                end
            end
        end
    end

    // Status snapshot for software
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[cell_pkg::STAT_Q_BIT] = cell_q;
        status_word[cell_pkg::STAT_LOCAL_BIT] = local_out_o;
        status_word[cell_pkg::STAT_GLOBAL_BIT] = global_out_o;
        status_word[cell_pkg::STAT_CARRY_BIT] = carry_out_o;
        status_word[cell_pkg::STAT_CASCADE_BIT] = cascade_out_o;
        status_word[cell_pkg::STAT_TRI_BIT] = tri_bus_o;
        status_word[cell_pkg::STAT_OVERRIDE_BIT] = override_act;
    end

    // Next state: flop update and AXI4-Lite slave
    always_comb begin
        next_state = state;
        // Async override wins; otherwise only an enabled edge updates
        if (override_act) begin
            next_state.phys_q = clr_n;
        end else if (ce_eff) begin
            next_state.phys_q = inverted ? ~next_q : next_q;
        end
        // Address and data are taken in either order, one write at a time
        if (awvalid_i && awready_o) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = awaddr_i;
        end
        if (wvalid_i && wready_o) begin
            next_state.w_held = 1'b1;
            next_state.w_data = wdata_i;
            next_state.w_strb = wstrb_i;
        end
        if (state.aw_held && state.w_held) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = cell_pkg::RESP_OKAY;
            unique case (reg_index(state.aw_addr))
                2'h0: next_state.config_word = merge(state.config_word, state.w_data, state.w_strb);
                2'h1: next_state.lut_mask = 16'(merge({16'h0000, state.lut_mask}, state.w_data, state.w_strb));
                2'h2: next_state.bresp = cell_pkg::RESP_OKAY; // Status ignores writes
                2'h3: next_state.bresp = cell_pkg::RESP_SLVERR;
            endcase
        end
        if (state.bvalid && bready_i) begin
            next_state.bvalid = 1'b0;
        end
        // Reads answer one cycle after the address is taken
        if (arvalid_i && arready_o) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = cell_pkg::RESP_OKAY;
            unique case (reg_index(araddr_i))
                2'h0: next_state.rdata = state.config_word;
                2'h1: next_state.rdata = {16'h0000, state.lut_mask};
                2'h2: next_state.rdata = status_word;
                2'h3: begin
                    next_state.rdata = 32'h0000_0000;
                    next_state.rresp = cell_pkg::RESP_SLVERR;
                end
            endcase
        end else if (state.rvalid && rready_i) begin
            next_state.rvalid = 1'b0;
        end
    end

    // Single state register with synchronous reset
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state <= '0;
            state.config_word <= cell_pkg::CONFIG_RESET;
            state.lut_mask <= cell_pkg::LUT_MASK_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Handshake outputs; a held item blocks its channel until the answer goes
    assign awready_o = ~state.aw_held & ~state.bvalid;
    assign wready_o = ~state.w_held & ~state.bvalid;
    assign bvalid_o = state.bvalid;
    assign bresp_o = state.bresp;
    assign arready_o = ~state.rvalid;
    assign rvalid_o = state.rvalid;
    assign rdata_o = state.rdata;
    assign rresp_o = state.rresp;

    // Checks next to the logic they guard
    a_clear_either_line: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (scheme == cell_pkg::SCH_CLEAR && (group_control_first_i || group_control_second_i)
         && !(chip_reset_en && !chip_reset_n_i)) |-> (cell_q == 1'b0) ##1 (state.phys_q == 1'b0 || override_act))
        else $error("clear scheme did not clear");
    a_preset_then_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (scheme == cell_pkg::SCH_CLEAR_PRESET && !(chip_reset_en && !chip_reset_n_i))
        |-> (group_control_second_i ? cell_q == 1'b0 : (group_control_first_i ? cell_q == 1'b1 : 1'b1)))
        else $error("clear-preset lines wrong");
    a_load_copies_c: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (scheme == cell_pkg::SCH_LOAD_ONLY && group_control_first_i && !(chip_reset_en && !chip_reset_n_i))
        |-> cell_q == cell_input_c_i)
        else $error("load did not copy input c");
    a_load_preset_line: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (scheme == cell_pkg::SCH_LOAD_PRESET && group_control_second_i && !(chip_reset_en && !chip_reset_n_i))
        |-> cell_q == 1'b1)
        else $error("load-preset second line did not preset");
    a_chip_reset_wins: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (chip_reset_en && !chip_reset_n_i) |-> (cell_q == inverted) ##1 (state.phys_q == 1'b0))
        else $error("chip reset not overriding");
    a_hold_without_ce: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!override_act && !ce_eff) |=> (state.phys_q == $past(state.phys_q)))
        else $error("register moved without enable");
    a_tri_resolve: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tri_enable_i == 4'h0 |-> tri_bus_o == 1'b1) and ($countones(tri_enable_i) > 1 |-> tri_bus_o == 1'b0))
        else $error("tri-state emulation resolved wrongly");
    a_packed_no_cascade: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (mode == cell_pkg::MODE_NORMAL && packed_reg) |-> cascade_out_o == lut_out)
        else $error("packed cell used the cascade");
    a_sync_clear_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (mode == cell_pkg::MODE_CLEARABLE && !cascade_in_i && ce_eff && !override_act
         && ff_type == cell_pkg::FF_D && !inverted) |=> (state.phys_q == 1'b0))
        else $error("clearable counter did not clear");
endmodule // logic_cell

/* verification/neighbour_cell.sv */
/*
 * Behavioural neighbour cell that feeds the carry and cascade chain inputs.
 * Assumes it shares clk_i with the cell under test.
 */
`timescale 1ns/1ps
module neighbour_cell (
    input wire logic clk_i,
    input wire logic carry_want_i,
    input wire logic cascade_want_i,
    output logic carry_o,
    output logic cascade_o
);
    // Chain outputs leave the neighbour's register, so they lag by one edge
    always_ff @(posedge clk_i) begin
        carry_o <= carry_want_i;
        cascade_o <= cascade_want_i;
    end
endmodule // neighbour_cell

/* verification/tb.sv */
/*
 * Self-checking bench for logic_cell: registers, async schemes, enable,
 * arithmetic, cascade and tri-state. Assumes neighbour_cell on the chains.
 */
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] CFG = cell_pkg::CONFIG_OFFSET;
    localparam logic [7:0] LUT = cell_pkg::LUT_MASK_OFFSET;
    logic clk_i = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, a = 1'b0, b = 1'b0, c = 1'b0, d = 1'b0, gc1 = 1'b0, gc2 = 1'b0, chip_n = 1'b1;
    logic carry_want = 1'b0, cascade_want = 1'b0, carry_in, cascade_in;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd_data, rdata;
    logic [3:0] tri_d = 4'h0, tri_e = 4'h0;
    logic [1:0] resp, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, loc, cout, casc, tri_bus, glb;
    int bad_count = 0, checks_done = 0;
    // Only the write strobes are tied: every register write is a full word
    logic_cell dut_u (.clk_i(clk_i), .resetn_i(rst_n), .awvalid_i(awvalid), .awready_o(awready),
        .awaddr_i(awaddr), .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(4'hf),
        .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready),
        .araddr_i(araddr), .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp),
        .cell_input_a_i(a), .cell_input_b_i(b), .cell_input_c_i(c), .cell_input_d_i(d),
        .carry_in_i(carry_in), .cascade_in_i(cascade_in), .group_control_first_i(gc1),
        .group_control_second_i(gc2), .chip_reset_n_i(chip_n), .tri_data_i(tri_d), .tri_enable_i(tri_e),
        .local_out_o(loc), .global_out_o(glb), .carry_out_o(cout), .cascade_out_o(casc), .tri_bus_o(tri_bus));
    neighbour_cell nb_u (.clk_i(clk_i), .carry_want_i(carry_want), .cascade_want_i(cascade_want),
        .carry_o(carry_in), .cascade_o(cascade_in));
    // 200 MHz clock
    initial forever #2.5 clk_i = ~clk_i;
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Ready is looked at mid-cycle; inputs only move at rising edges, so it equals the sampled value
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        logic aw_t, w_t, b_t;
        @(posedge clk_i);
        awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= ad; wdata <= dt; bready <= 1'b1;
        forever begin
            @(negedge clk_i);
            aw_t = awvalid & awready; w_t = wvalid & wready; b_t = bvalid; resp = bresp;
            @(posedge clk_i);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) begin bready <= 1'b0; break; end
        end
    endtask
    task automatic rd(input logic [7:0] ad);
        logic ar_t, r_t;
        @(posedge clk_i);
        arvalid <= 1'b1; araddr <= ad; rready <= 1'b1;
        forever begin
            @(negedge clk_i);
            ar_t = arvalid & arready; r_t = rvalid; rd_data = rdata; resp = rresp;
            @(posedge clk_i);
            if (ar_t) arvalid <= 1'b0;
            if (r_t) begin rready <= 1'b0; break; end
        end
    endtask
    // One async scheme: local output shows the register, controls act within the cycle
    task automatic as(input logic [2:0] s, input logic g1, input logic g2, input logic cv, input logic ex);
        wr(CFG, 32'h0000_4000 | {27'h0, s, 2'h0});
        @(posedge clk_i) begin gc1 <= g1; gc2 <= g2; c <= cv; end
        @(negedge clk_i) chk(loc === ex, "async scheme result");
        @(posedge clk_i) begin gc1 <= 1'b0; gc2 <= 1'b0; end
    endtask
    task automatic t_regs();
        rd(CFG); chk(rd_data === cell_pkg::CONFIG_RESET && resp === cell_pkg::RESP_OKAY, "config reset");
        rd(LUT); chk(rd_data[15:0] === cell_pkg::LUT_MASK_RESET, "mask reset");
        rd(8'h0c); chk(resp === cell_pkg::RESP_SLVERR, "unmapped read");
        wr(8'h0c, 32'h0); chk(resp === cell_pkg::RESP_SLVERR, "unmapped write");
        wr(LUT, 32'hffff_ffff); rd(LUT); chk(rd_data === 32'h0000_ffff, "mask upper bits");
    endtask
    task automatic t_async();
        as(3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
        as(3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        as(3'h2, 1'b0, 1'b1, 1'b0, 1'b0);
        as(3'h3, 1'b1, 1'b0, 1'b0, 1'b0);
        as(3'h3, 1'b0, 1'b1, 1'b1, 1'b0);
        as(3'h5, 1'b1, 1'b0, 1'b0, 1'b0);
        wr(CFG, 32'h0001_4000);
        @(posedge clk_i) chip_n <= 1'b0;
        @(negedge clk_i) chk(loc === 1'b0, "chip reset wins");
        @(posedge clk_i) chip_n <= 1'b1;
        wr(LUT, 32'h0);
        as(3'h1, 1'b1, 1'b0, 1'b1, 1'b1);
        as(3'h2, 1'b1, 1'b0, 1'b0, 1'b1);
        as(3'h3, 1'b1, 1'b0, 1'b1, 1'b1);
        as(3'h4, 1'b0, 1'b1, 1'b0, 1'b1);
        as(3'h5, 1'b1, 1'b0, 1'b1, 1'b1);
    endtask
    task automatic t_cells();
        // Enable comes from input a; the register must hold while a is low
        wr(CFG, 32'h0000_4040); wr(LUT, 32'hffff); @(negedge clk_i) chk(loc === 1'b0, "held");
        @(posedge clk_i) a <= 1'b1;
        @(posedge clk_i); @(negedge clk_i) chk(loc === 1'b1, "enabled load");
        // Sum and carry tables are symmetric, so input order cannot matter
        wr(LUT, 32'h0000_e896); wr(CFG, 32'h0000_0101);
        @(posedge clk_i) begin b <= 1'b1; cascade_want <= 1'b1; end
        repeat (2) @(posedge clk_i);
        @(negedge clk_i) chk(loc === 1'b0 && cout === 1'b1 && casc === 1'b0, "add 1+1");
        @(posedge clk_i) begin a <= 1'b0; b <= 1'b0; carry_want <= 1'b1; end
        repeat (2) @(posedge clk_i);
        @(negedge clk_i) chk(loc === 1'b1 && cout === 1'b0 && casc === 1'b1, "add carry");
        @(posedge clk_i) begin tri_d <= 4'hf; end
        @(negedge clk_i) chk(tri_bus === 1'b1, "floating bus");
        @(posedge clk_i) begin tri_e <= 4'h3; tri_d <= 4'h1; end
        @(negedge clk_i) chk(tri_bus === 1'b0, "contention");
        @(posedge clk_i) begin tri_e <= 4'h4; tri_d <= 4'hb; end
        @(negedge clk_i) chk(tri_bus === 1'b0, "single driver");
    endtask
    task automatic t_more();
        logic tq;
        // Packed: d feeds the register onto global, table drives local, no cascade
        @(posedge clk_i) d <= 1'b1;
        wr(LUT, 32'h0000_00ff);
        wr(CFG, 32'h0000_8700);
        @(negedge clk_i) chk(glb === 1'b1 && loc === 1'b0 && casc === 1'b0, "packed cell");
        // Up/down: load 0 through d, then count down with a borrow out
        @(posedge clk_i) begin c <= 1'b0; b <= 1'b0; end
        wr(LUT, 32'h0000_2866);
        wr(CFG, 32'h0000_4002);
        @(negedge clk_i) chk(loc === 1'b0 && cout === 1'b0, "count load");
        @(posedge clk_i) begin d <= 1'b0; b <= 1'b1; end
        @(negedge clk_i) chk(loc === 1'b0 && cout === 1'b1, "down borrow");
        @(posedge clk_i);
        @(negedge clk_i) chk(loc === 1'b1 && cout === 1'b0, "count step");
        // Clearable: load 1, then the low clear on cascade-in beats the load
        @(posedge clk_i) begin b <= 1'b0; c <= 1'b1; d <= 1'b1; end
        wr(CFG, 32'h0000_4003);
        @(negedge clk_i) chk(loc === 1'b1, "clearable load");
        @(posedge clk_i) cascade_want <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i) chk(loc === 1'b0, "sync clear");
        // Preset built from the clear with register input and output inverted
        wr(CFG, 32'h0000_4024);
        @(posedge clk_i) gc1 <= 1'b1;
        @(negedge clk_i) chk(loc === 1'b1, "inverted preset");
        rd(cell_pkg::STATUS_OFFSET);
        chk(rd_data[cell_pkg::STAT_Q_BIT] === 1'b1 && rd_data[cell_pkg::STAT_OVERRIDE_BIT] === 1'b1, "status");
        @(posedge clk_i) gc1 <= 1'b0;
        // Toggle flop with the table held high flips on every edge
        wr(LUT, 32'h0000_ffff);
        wr(CFG, 32'h0000_4800);
        @(negedge clk_i) tq = loc;
        @(negedge clk_i) chk(loc === ~tq, "toggle");
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n <= 1'b1;
        t_regs();
        t_async();
        t_cells();
        t_more();
        summarize();
    end
    // Watchdog: the run needs well under a thousand cycles
    initial begin
        #20000;
        bad_count++;
        summarize();
    end
endmodule // tb
